// ===== bofr_cfg.svh
// Constants for the wide-input regulator fault-response block.
`ifndef BOFR_CFG_SVH
`define BOFR_CFG_SVH
`define BOFR_CLK_MHZ          100
`define BOFR_SINK_FILTER_US   20
`define BOFR_SINK_FILTER_CYC  (`BOFR_SINK_FILTER_US * `BOFR_CLK_MHZ)
`define BOFR_RESET_TIMEOUT    32'h000F4240
`define BOFR_ERR_LIMIT        4'h7
`define BOFR_STAGE_DELAY_CYC  16'h0064
// Register offsets on the plain register port.
`define BOFR_REG_STATUS       4'h0
`define BOFR_REG_CONFIG       4'h1
`define BOFR_REG_IRQ_EN       4'h2
`define BOFR_REG_IRQ_CLR      4'h3
`define BOFR_REG_STATE        4'h4
`define BOFR_REG_LATCH        4'h5
// Status field positions.
`define BOFR_ST_OVERLOAD      0
`define BOFR_ST_SHORT         1
`define BOFR_ST_SINK          2
`define BOFR_ST_OVP           3
`define BOFR_ST_TIMEOUT       4
`define BOFR_ST_WIDTH         5
// Configuration field positions and register reset values.
`define BOFR_CF_SHORT_OFF     0
`define BOFR_CF_SINK_OFF      1
`define BOFR_CF_UV_RESET      2
`define BOFR_CONFIG_RESET     3'h4
`define BOFR_IRQ_EN_RESET     5'h0A
`endif

// ===== bofr_pkg.sv
// Types for the wide-input regulator fault-response block.
package bofr_pkg;
    typedef enum logic [4:0] {
        BOFR_ACTIVE = 5'h01,
        BOFR_CLAMP  = 5'h02,
        BOFR_SAFE   = 5'h04,
        BOFR_RESET  = 5'h08,
        BOFR_OFF    = 5'h10
    } bofr_state_type;
endpackage : bofr_pkg

// ===== buck_overcurrent_fault_response.sv
// Fault-response sequencer for the wide-input step-down regulator.
// Notes on behaviour
// - Overload on either transistor sets overload flag; regulator keeps running.
// - Short circuit: high side off, low side on until below overload, then disable.
// - Short with off select 1: all regulators off, discharge on, enter OFF.
// - Short-circuit flag held in always-on latch through OFF, reported at power-up.
// - Short with off select 0: all regulators off, discharge off, enter SAFE.
// - In SAFE, outputs below undervoltage and undervoltage reset enabled: enter RESET.
// - In RESET wide-input regulator on, then low-voltage buck, then boost.
// - In RESET monitoring stays active; critical fault keeps wide-input regulator off.
// - RESET timeout without recovery moves device to OFF.
// - Short circuit through SAFE path drives interrupt low, increments error counter.
// - Sink overcurrent sets flag; persisting past 20 us turns regulator off.
// - Sink fault with off select 1 enters OFF, latch holds sink indication.
// - Sink fault with off select 0 enters SAFE, interrupt low, counter increments.
// - Sink detection masked from regulator enable until output passes undervoltage.
// - Overvoltage protection flag disables the wide-input regulator.
// - Fixed switching frequency, lowered only when on/off-time limits force it.
// - Error counter at power-down threshold sends the next fault to OFF instead of SAFE.
`include "bofr_cfg.svh"
module buck_overcurrent_fault_response #(
    parameter int unsigned SINK_FILTER_CYC = `BOFR_SINK_FILTER_CYC,
    parameter int unsigned RESET_TIMEOUT   = `BOFR_RESET_TIMEOUT,
    parameter int unsigned SWITCH_DIV      = 45
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        hsOverload,
    input  wire logic        lsOverload,
    input  wire logic        hsShort,
    input  wire logic        lsShort,
    input  wire logic        lsSink,
    input  wire logic        ovpDetect,
    input  wire logic        minTimeLimit,
    input  wire logic        wideUvOk,
    input  wire logic        lowBuckUvOk,
    input  wire logic        allBelowUv,
    input  wire logic        powerUp,
    input  wire logic [3:0]  regAddr,
    input  wire logic [7:0]  regWdata,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic      [7:0]  regRdata,
    output logic             highSideOn,
    output logic             lowSideOn,
    output logic             wideEnable,
    output logic             lowBuckEnable,
    output logic             boostEnable,
    output logic             dischargeEnable,
    output logic             switchTick,
    output logic             interrupt_out_n
);
    // Refuse counts the counters cannot hold; the timeout must outlast the boost stage delay.
    if (SINK_FILTER_CYC < 1 || SWITCH_DIV < 2 || SWITCH_DIV > 256 ||
        RESET_TIMEOUT <= `BOFR_STAGE_DELAY_CYC) begin : g_param_check
        $error("buck_overcurrent_fault_response: parameter out of range");
    end

    bofr_pkg::bofr_state_type state;
    bofr_pkg::bofr_state_type next_state;
    logic [`BOFR_ST_WIDTH-1:0] regulator_safety_status;
    logic [`BOFR_ST_WIDTH-1:0] irqEnable;
    logic [`BOFR_ST_WIDTH-1:0] statusSet;
    logic [`BOFR_ST_WIDTH-1:0] statusClr;
    logic [2:0]  cfgBits;
    logic [1:0]  analogLatch;
    logic [1:0]  latchSet;
    logic [1:0]  latchClr;
    logic [3:0]  errorCount;
    logic [31:0] sinkCount;
    logic [31:0] resetCount;
    logic [15:0] stageCount;
    logic [7:0]  divCount;
    logic        sinkMasked;
    logic        anyShort;
    logic        anyOverload;
    logic        sinkFault;
    logic        shortDone;
    logic        critical;
    logic        toSafe;
    logic        short_circuit_off_select;
    logic        sink_fault_off_select;
    logic        undervoltage_reset_select;

    assign short_circuit_off_select  = cfgBits[`BOFR_CF_SHORT_OFF];
    assign sink_fault_off_select     = cfgBits[`BOFR_CF_SINK_OFF];
    assign undervoltage_reset_select = cfgBits[`BOFR_CF_UV_RESET];

    // Fault qualification; a short overrides a plain overload.
    assign anyShort    = hsShort | lsShort;
    assign anyOverload = (hsOverload | lsOverload) & ~anyShort;
    assign shortDone   = (state == bofr_pkg::BOFR_CLAMP) & ~lsOverload;
    assign sinkFault   = (sinkCount >= SINK_FILTER_CYC);
    assign critical    = anyShort | ovpDetect | sinkFault;
    assign toSafe      = errorCount < `BOFR_ERR_LIMIT;

    // Sink detection is blanked while the regulator ramps after enable.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sinkMasked <= 1'b1;
        end else if (!wideEnable) begin
            sinkMasked <= 1'b1;
        end else if (wideUvOk) begin
            sinkMasked <= 1'b0;
        end
    end

    // Duration filter for low-side sink overcurrent.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sinkCount <= 32'h0;
        end else if (lsSink && !sinkMasked && wideEnable) begin
            if (!sinkFault) begin
                sinkCount <= sinkCount + 32'h1;
            end
        end else begin
            sinkCount <= 32'h0;
        end
    end

    // Next-state logic of the fault sequencer.
    always_comb begin
        next_state = state;
        case (state)
            bofr_pkg::BOFR_ACTIVE: begin
                if (anyShort) begin
                    next_state = bofr_pkg::BOFR_CLAMP;
                end else if (sinkFault) begin
                    next_state = (sink_fault_off_select || !toSafe) ? bofr_pkg::BOFR_OFF
                                                                    : bofr_pkg::BOFR_SAFE;
                end else if (ovpDetect) begin
                    next_state = toSafe ? bofr_pkg::BOFR_SAFE : bofr_pkg::BOFR_OFF;
                end
            end
            bofr_pkg::BOFR_CLAMP: begin
                if (shortDone) begin
                    next_state = (short_circuit_off_select || !toSafe) ? bofr_pkg::BOFR_OFF
                                                                       : bofr_pkg::BOFR_SAFE;
                end
            end
            bofr_pkg::BOFR_SAFE: begin
                if (allBelowUv && undervoltage_reset_select) begin
                    next_state = bofr_pkg::BOFR_RESET;
                end
            end
            bofr_pkg::BOFR_RESET: begin
                if (resetCount >= RESET_TIMEOUT) begin
                    next_state = bofr_pkg::BOFR_OFF;
                end else if (boostEnable && !critical) begin
                    next_state = bofr_pkg::BOFR_ACTIVE;
                end
            end
            bofr_pkg::BOFR_OFF: begin
                if (powerUp) begin
                    next_state = bofr_pkg::BOFR_RESET;
                end
            end
            default: begin
                next_state = bofr_pkg::BOFR_OFF;
            end
        endcase
    end

    // State register.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= bofr_pkg::BOFR_RESET;
        end else begin
            state <= next_state;
        end
    end

    // RESET timeout and staging counters.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            resetCount <= 32'h0;
            stageCount <= 16'h0;
        end else if (state != bofr_pkg::BOFR_RESET) begin
            resetCount <= 32'h0;
            stageCount <= 16'h0;
        end else begin
            resetCount <= resetCount + 32'h1;
            if (lowBuckEnable && stageCount < `BOFR_STAGE_DELAY_CYC) begin
                stageCount <= stageCount + 16'h1;
            end
        end
    end

    // Regulator enables: staged re-enable in RESET, all off in SAFE/OFF.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wideEnable      <= 1'b0;
            lowBuckEnable   <= 1'b0;
            boostEnable     <= 1'b0;
            dischargeEnable <= 1'b0;
        end else begin
            case (next_state)
                bofr_pkg::BOFR_RESET: begin
                    wideEnable      <= ~critical;
                    lowBuckEnable   <= ~critical & wideEnable & wideUvOk;
                    boostEnable     <= ~critical & lowBuckEnable & lowBuckUvOk &
                                       (stageCount >= `BOFR_STAGE_DELAY_CYC);
                    dischargeEnable <= 1'b0;
                end
                bofr_pkg::BOFR_ACTIVE: begin
                    wideEnable      <= 1'b1;
                    lowBuckEnable   <= lowBuckEnable;
                    boostEnable     <= boostEnable;
                    dischargeEnable <= 1'b0;
                end
                bofr_pkg::BOFR_CLAMP: begin
                    wideEnable      <= 1'b1;
                    lowBuckEnable   <= lowBuckEnable;
                    boostEnable     <= boostEnable;
                    dischargeEnable <= 1'b0;
                end
                bofr_pkg::BOFR_OFF: begin
                    wideEnable      <= 1'b0;
                    lowBuckEnable   <= 1'b0;
                    boostEnable     <= 1'b0;
                    dischargeEnable <= 1'b1;
                end
                default: begin
                    wideEnable      <= 1'b0;
                    lowBuckEnable   <= 1'b0;
                    boostEnable     <= 1'b0;
                    dischargeEnable <= 1'b0;
                end
            endcase
        end
    end

    // Switching clock: fixed period, stretched while on/off-time limits bind.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            divCount   <= 8'h0;
            switchTick <= 1'b0;
        end else if (divCount >= 8'(SWITCH_DIV - 1) && !minTimeLimit) begin
            divCount   <= 8'h0;
            switchTick <= wideEnable;
        end else begin
            if (divCount < 8'(SWITCH_DIV - 1)) begin
                divCount <= divCount + 8'h1;
            end
            switchTick <= 1'b0;
        end
    end

    // Power stage: high side off at once on a short, low side clamped on.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            highSideOn <= 1'b0;
            lowSideOn  <= 1'b0;
        end else if (next_state == bofr_pkg::BOFR_CLAMP) begin
            highSideOn <= 1'b0;
            lowSideOn  <= 1'b1;
        end else if (next_state == bofr_pkg::BOFR_ACTIVE) begin
            highSideOn <= ~anyShort;
            lowSideOn  <= 1'b0;
        end else begin
            highSideOn <= 1'b0;
            lowSideOn  <= 1'b0;
        end
    end

    // Error counter counts SAFE-path faults; cleared by a fresh power-up.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            errorCount <= 4'h0;
        end else if (state == bofr_pkg::BOFR_OFF && powerUp) begin
            errorCount <= 4'h0;
        end else if (next_state == bofr_pkg::BOFR_SAFE && state != bofr_pkg::BOFR_SAFE) begin
            errorCount <= errorCount + 4'h1;
        end
    end

    // Always-on latch keeps OFF-path fault causes for the next power-up; a new cause wins over a clear.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            analogLatch <= 2'h0;
        end else begin
            analogLatch <= (analogLatch & ~latchClr) | latchSet;
        end
    end

    // Latch clear by software and latch set on entry into OFF.
    assign latchClr = (regWrite && regAddr == `BOFR_REG_LATCH) ? regWdata[1:0] : 2'h0;
    assign latchSet = (next_state == bofr_pkg::BOFR_OFF && state != bofr_pkg::BOFR_OFF) ?
                      {sinkFault, state == bofr_pkg::BOFR_CLAMP} : 2'h0;

    // Sticky status events; a set wins over a clear in the same cycle.
    assign statusSet[`BOFR_ST_OVERLOAD] = anyOverload & wideEnable;
    assign statusSet[`BOFR_ST_SHORT]    = shortDone | (state == bofr_pkg::BOFR_OFF & powerUp & analogLatch[0]);
    assign statusSet[`BOFR_ST_SINK]     = (lsSink & ~sinkMasked & wideEnable) |
                                          (state == bofr_pkg::BOFR_OFF & powerUp & analogLatch[1]);
    assign statusSet[`BOFR_ST_OVP]      = ovpDetect;
    assign statusSet[`BOFR_ST_TIMEOUT]  = (state == bofr_pkg::BOFR_RESET) & (next_state == bofr_pkg::BOFR_OFF);
    assign statusClr = (regWrite && regAddr == `BOFR_REG_IRQ_CLR) ? regWdata[`BOFR_ST_WIDTH-1:0]
                                                                  : '0;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            regulator_safety_status <= '0;
        end else begin
            regulator_safety_status <= (regulator_safety_status & ~statusClr) | statusSet;
        end
    end

    // Configuration and interrupt enable registers.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfgBits   <= `BOFR_CONFIG_RESET;
            irqEnable <= `BOFR_IRQ_EN_RESET;
        end else if (regWrite) begin
            if (regAddr == `BOFR_REG_CONFIG) begin
                cfgBits <= regWdata[2:0];
            end
            if (regAddr == `BOFR_REG_IRQ_EN) begin
                irqEnable <= regWdata[`BOFR_ST_WIDTH-1:0];
            end
        end
    end

    // Read data one cycle after the read strobe; unmapped reads give zero.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            regRdata <= 8'h00;
        end else if (regRead) begin
            case (regAddr)
                `BOFR_REG_STATUS: regRdata <= {3'h0, regulator_safety_status};
                `BOFR_REG_CONFIG: regRdata <= {5'h00, cfgBits};
                `BOFR_REG_IRQ_EN: regRdata <= {3'h0, irqEnable};
                `BOFR_REG_STATE:  regRdata <= {errorCount[2:0], state};
                `BOFR_REG_LATCH:  regRdata <= {6'h00, analogLatch};
                default:          regRdata <= 8'h00;
            endcase
        end else begin
            regRdata <= 8'h00;
        end
    end

    // Active-low level interrupt while any enabled status bit is set.
    assign interrupt_out_n = ~|(regulator_safety_status & irqEnable);

    AST_SHORT_HS_OFF: assert property (@(posedge clk) disable iff (!arst_n)
        anyShort |=> !highSideOn) else $error("high side on after short");
    AST_CLAMP_LS_ON: assert property (@(posedge clk) disable iff (!arst_n)
        state == bofr_pkg::BOFR_CLAMP |-> lowSideOn) else $error("low side not clamped");
    AST_SHORT_OFF: assert property (@(posedge clk) disable iff (!arst_n)
        shortDone && short_circuit_off_select |=> state == bofr_pkg::BOFR_OFF && analogLatch[0])
        else $error("short did not reach OFF");
    AST_OFF_DISCHARGE: assert property (@(posedge clk) disable iff (!arst_n)
        state == bofr_pkg::BOFR_OFF |-> dischargeEnable && !wideEnable) else $error("OFF outputs wrong");
    AST_SAFE_QUIET: assert property (@(posedge clk) disable iff (!arst_n)
        state == bofr_pkg::BOFR_SAFE |-> !wideEnable && !boostEnable && !dischargeEnable)
        else $error("SAFE outputs wrong");
    AST_SAFE_TO_RESET: assert property (@(posedge clk) disable iff (!arst_n)
        state == bofr_pkg::BOFR_SAFE && allBelowUv && undervoltage_reset_select |=> state == bofr_pkg::BOFR_RESET)
        else $error("SAFE did not recover");
    AST_STAGE_ORDER: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(boostEnable) |-> lowBuckEnable) else $error("boost before low buck");
    AST_SAFE_COUNT: assert property (@(posedge clk) disable iff (!arst_n)
        state != bofr_pkg::BOFR_SAFE ##1 state == bofr_pkg::BOFR_SAFE |-> errorCount == $past(errorCount) + 4'h1)
        else $error("error counter missed");
    AST_ERR_LIMIT: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(state == bofr_pkg::BOFR_SAFE) |-> $past(errorCount) < `BOFR_ERR_LIMIT)
        else $error("SAFE entered past error limit");
    AST_SINK_MASK: assert property (@(posedge clk) disable iff (!arst_n)
        sinkMasked |-> sinkCount == 32'h0) else $error("sink counted while masked");
    AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (!arst_n)
        (regulator_safety_status & irqEnable) != '0 |-> !interrupt_out_n) else $error("irq not driven");
    COV_SHORT_SAFE: cover property (@(posedge clk) disable iff (!arst_n)
        state == bofr_pkg::BOFR_CLAMP ##1 state == bofr_pkg::BOFR_SAFE);
    COV_RECOVER: cover property (@(posedge clk) disable iff (!arst_n)
        state == bofr_pkg::BOFR_RESET ##1 state == bofr_pkg::BOFR_ACTIVE);
    COV_SINK_OFF: cover property (@(posedge clk) disable iff (!arst_n)
        sinkFault && sink_fault_off_select ##1 state == bofr_pkg::BOFR_OFF);

endmodule : buck_overcurrent_fault_response

// ===== bofr_mcu_model.sv
// Supervising microcontroller model on the register port and interrupt pin.
module bofr_mcu_model (
    input  wire logic       clk,
    input  wire logic [7:0] regRdata,
    input  wire logic       interrupt_out_n,
    output logic      [3:0] regAddr,
    output logic      [7:0] regWdata,
    output logic            regWrite,
    output logic            regRead
);
    timeunit 1ns;
    timeprecision 1ns;
    int irqCount;

    // The port starts idle and no interrupt has been seen.
    initial begin
        regAddr = 4'h0;
        regWdata = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        irqCount = 0;
    end

    // Counts every assertion of the active-low interrupt.
    always @(negedge interrupt_out_n) irqCount++;

    // One-cycle write; stale data is inverted so it never looks valid.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
        regWdata <= ~d;
    endtask : wr

    // One-cycle read; the data stand only in the following cycle.
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        d = regRdata;
    endtask : rd
endmodule : bofr_mcu_model

// ===== buck_overcurrent_fault_response_tb.sv
// Self-checking bench for the wide-input regulator fault-response block.
`include "bofr_cfg.svh"
module buck_overcurrent_fault_response_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk, arst_n, hsOverload, lsOverload, hsShort, lsShort, lsSink, ovpDetect, minTimeLimit;
    logic       wideUvOk, lowBuckUvOk, allBelowUv, powerUp, regWrite, regRead, highSideOn, lowSideOn;
    logic       wideEnable, lowBuckEnable, boostEnable, dischargeEnable, switchTick, interrupt_out_n;
    logic [3:0] regAddr;
    logic [7:0] regWdata, regRdata, d;
    int         mismatches, total_checks, expErr, seed, n;

    // Free-running 100 MHz clock.
    always #5 clk = ~clk;

    // Design with shortened filter and timeout counts; the timeout still outlasts the boost stage delay.
    buck_overcurrent_fault_response #(.SINK_FILTER_CYC(8), .RESET_TIMEOUT(150), .SWITCH_DIV(45))
    u_buck_overcurrent_fault_response (.clk(clk), .arst_n(arst_n), .hsOverload(hsOverload),
        .lsOverload(lsOverload), .hsShort(hsShort), .lsShort(lsShort), .lsSink(lsSink),
        .ovpDetect(ovpDetect), .minTimeLimit(minTimeLimit), .wideUvOk(wideUvOk), .lowBuckUvOk(lowBuckUvOk),
        .allBelowUv(allBelowUv), .powerUp(powerUp), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .highSideOn(highSideOn),
        .lowSideOn(lowSideOn), .wideEnable(wideEnable), .lowBuckEnable(lowBuckEnable),
        .boostEnable(boostEnable), .dischargeEnable(dischargeEnable), .switchTick(switchTick),
        .interrupt_out_n(interrupt_out_n));

    // Microcontroller on the far side of the register port.
    bofr_mcu_model u_bofr_mcu_model (.clk(clk), .regRdata(regRdata), .interrupt_out_n(interrupt_out_n),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead));

    // Compares one result with the model and counts it.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rdChk(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hFF);
        u_bofr_mcu_model.rd(a, d);
        chk(d & m, exp);
    endtask : rdChk
    function automatic logic [7:0] st(input bofr_pkg::bofr_state_type s);
        return {expErr[2:0], s};
    endfunction : st
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : cyc
    task automatic waitHi(ref logic s, input int lim);
        #1;
        for (int i = 0; i < lim && s !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
    endtask : waitHi
    // Wake from OFF; the error counter starts again at zero.
    task automatic powerCycle();
        @(posedge clk);
        powerUp <= 1'b1;
        wideUvOk <= 1'b1;
        @(posedge clk);
        powerUp <= 1'b0;
        waitHi(boostEnable, 300);
        expErr = 0;
    endtask : powerCycle
    task automatic results();
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results

    // One fault of the given kind with the given off select, then recovery.
    task automatic fault(input int kind, input logic sel);
        u_bofr_mcu_model.wr(`BOFR_REG_CONFIG, 8'h04 | (8'(sel) << kind));
        n = u_bofr_mcu_model.irqCount;
        @(posedge clk);
        hsShort <= kind == 0 && !sel;
        lsShort <= kind == 0 && sel;
        hsOverload <= kind == 0;
        lsOverload <= kind == 0;
        lsSink <= kind == 1;
        cyc(1);
        if (kind == 0) begin
            chk(8'({highSideOn, lowSideOn}), 8'h01);
            @(posedge clk);
            {hsShort, lsShort, hsOverload} <= 3'h0;
            cyc(3);
            chk(8'(lowSideOn), 8'h01);
            rdChk(`BOFR_REG_STATE, st(bofr_pkg::BOFR_CLAMP));
        end else cyc(12);
        @(posedge clk);
        {lsOverload, lsSink} <= 2'h0;
        cyc(3);
        chk(8'({wideEnable, lowBuckEnable, boostEnable, highSideOn}), 8'h00);
        if (sel) begin
            rdChk(`BOFR_REG_STATE, st(bofr_pkg::BOFR_OFF));
            chk(8'(dischargeEnable), 8'h01);
            rdChk(`BOFR_REG_LATCH, 8'h01 << kind);
            u_bofr_mcu_model.wr(`BOFR_REG_IRQ_CLR, 8'h1F);
            powerCycle();
            rdChk(`BOFR_REG_STATUS, 8'h02 << kind, 8'h02 << kind);
            u_bofr_mcu_model.wr(`BOFR_REG_LATCH, 8'h03);
            rdChk(`BOFR_REG_LATCH, 8'h00);
        end else begin
            expErr++;
            rdChk(`BOFR_REG_STATE, st(bofr_pkg::BOFR_SAFE));
            chk(8'({dischargeEnable, interrupt_out_n}), 8'h00);
            chk(8'(u_bofr_mcu_model.irqCount - n), 8'h01);
            rdChk(`BOFR_REG_STATUS, kind ? 8'h04 : 8'h03);
            @(posedge clk);
            allBelowUv <= 1'b1;
            waitHi(wideEnable, 20);
            @(posedge clk);
            allBelowUv <= 1'b0;
            waitHi(boostEnable, 300);
            cyc(2);
            rdChk(`BOFR_REG_STATE, st(bofr_pkg::BOFR_ACTIVE));
        end
        u_bofr_mcu_model.wr(`BOFR_REG_IRQ_CLR, 8'h1F);
    endtask : fault

    // Cuts a hung run short.
    initial begin
        #200000;
        mismatches++;
        results();
    end

    // Main sequence.
    initial begin
        seed = 39319;
        clk = 0;
        arst_n = 0;
        {hsOverload, lsOverload, hsShort, lsShort, ovpDetect, minTimeLimit, allBelowUv, powerUp} = 8'h00;
        {wideUvOk, lowBuckUvOk, lsSink} = 3'h3;
        expErr = 0;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        cyc(10);
        chk(8'({wideEnable, lowBuckEnable}), 8'h02);
        rdChk(`BOFR_REG_STATUS, 8'h00, 8'h04);
        cyc(160);
        rdChk(`BOFR_REG_STATE, st(bofr_pkg::BOFR_OFF));
        lsSink <= 1'b0;
        powerCycle();
        chk(8'({wideEnable, lowBuckEnable, boostEnable}), 8'h07);
        u_bofr_mcu_model.wr(`BOFR_REG_IRQ_CLR, 8'h1F);
        rdChk(`BOFR_REG_CONFIG, 8'h04);
        rdChk(`BOFR_REG_IRQ_EN, 8'h0A);
        rdChk(4'(6 + $unsigned($random(seed)) % 10), 8'h00);
        // Overload only flags; the interrupt follows its enable and clear.
        @(posedge clk);
        hsOverload <= 1'b1;
        repeat (1 + $unsigned($random(seed)) % 4) @(posedge clk);
        hsOverload <= 1'b0;
        rdChk(`BOFR_REG_STATUS, 8'h01);
        chk(8'({wideEnable, interrupt_out_n}), 8'h03);
        u_bofr_mcu_model.wr(`BOFR_REG_IRQ_EN, 8'h0B);
        #1 chk(8'(interrupt_out_n), 8'h00);
        u_bofr_mcu_model.wr(`BOFR_REG_IRQ_CLR, 8'h01);
        #1 chk(8'(interrupt_out_n), 8'h01);
        u_bofr_mcu_model.wr(`BOFR_REG_IRQ_EN, 8'h0E);
        // A sink event shorter than the filter only flags.
        @(posedge clk);
        lsSink <= 1'b1;
        repeat (1 + $unsigned($random(seed)) % 6) @(posedge clk);
        lsSink <= 1'b0;
        rdChk(`BOFR_REG_STATUS, 8'h04);
        chk(8'(wideEnable), 8'h01);
        u_bofr_mcu_model.wr(`BOFR_REG_IRQ_CLR, 8'h1F);
        // Switching period, plain and stretched.
        waitHi(switchTick, 200);
        for (n = 1; n < 200; n++) begin
            cyc(1);
            if (switchTick === 1'b1) break;
        end
        chk(8'(n), 8'h2D);
        // The on/off-time limit held for 60 cycles holds the next tick until its release.
        minTimeLimit <= 1'b1;
        for (n = 1; n < 200; n++) begin
            cyc(1);
            if (n == 60) minTimeLimit <= 1'b0;
            if (switchTick === 1'b1) break;
        end
        chk(8'(n), 8'h3D);
        for (int k = 0; k < 4; k++) fault(k / 2, 1'(k % 2));
        @(posedge clk);
        ovpDetect <= 1'b1;
        cyc(4);
        chk(8'(wideEnable), 8'h00);
        rdChk(`BOFR_REG_STATUS, 8'h08, 8'h08);
        results();
    end
endmodule : buck_overcurrent_fault_response_tb
